/* File: edasw_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - An access begins with a four-clock opcode fetch, then the address is driven and the access performed.
// - The low three bits of the clock control register select a stretch of 0 to 7, giving 2 to 9 machine cycles.
// - Stretch lengthens only external data accesses, holding the core frozen meanwhile.
// - The stretch resets to 1, giving a three-machine-cycle access.
// - Strobe width is 2 clocks at stretch 0, and 4 times the stretch otherwise.
// - The wait input is honoured only while the wait-enable bit 7 of the memory map control register is set.
// - With wait on, the stretch still sets the minimum length.
// - Wait is sampled in the second clock state of each access cycle before the strobe rises.
// - Only a wait sample in the last or an inserted machine cycle adds one machine cycle, without limit.
// - The wait-enable bit changes only through the timed-access sequence.
// - The indirect form takes the low address from the working register and the high from port 2.
// - The pointer form takes the whole address from the selected data pointer.
// - Bit 0 of the pointer select register at 86h picks the pointer; the other bits read 0.
module edasw_core (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // Special function register write/read port
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        clk_ctrl_wr,
   input  wire logic        mmap_wr,
   input  wire logic        ta_wr,
   output var  logic [7:0]  clk_ctrl_rdata,
   output var  logic [7:0]  mmap_rdata,
   output var  logic [7:0]  ptr_sel_rdata,
   // Access request from the core
   input  wire logic        xacc_start,
   input  wire logic        xacc_write,
   input  wire logic        xacc_use_ptr,
   input  wire logic [7:0]  work_reg_lo,
   input  wire logic [7:0]  port2_hi,
   input  wire logic [15:0] data_ptr0,
   input  wire logic [15:0] second_data_pointer,
   output var  logic        core_hold,
   output var  logic        xacc_done,
   // External bus
   input  wire logic        port4_bit0_pin_n,
   output var  logic [15:0] ext_addr,
   output var  logic        ext_rd_n,
   output var  logic        ext_wr_n
);
   import edasw_pkg::*;

   typedef struct packed {
      edasw_state_e state;
      logic [1:0]   phase;
      logic [3:0]   mc_left;
      logic [4:0]   strb_cnt;
      logic         wait_hit;
      logic         is_write;
      logic [2:0]   access_stretch_field;
      logic         wait_enable_bit;
      logic         pointer_select_bit;
      logic [1:0]   ta_step;
      logic [2:0]   ta_timer;
      logic [15:0]  addr;
      logic         rd_n;
      logic         wr_n;
      logic         hold;
      logic         done;
   } edasw_s;

   edasw_s st_reg;
   edasw_s st_next;
   logic   ta_open;
   logic [4:0] strb_clks;

   // Strobe clocks: 2 at stretch 0, else 4 per step
   always_comb begin
      if (st_reg.access_stretch_field == 3'h0) begin
         strb_clks = 5'h02;
      end else begin
         strb_clks = {st_reg.access_stretch_field, 2'h0};
      end
   end

   assign ta_open = (st_reg.ta_step == 2'h2) && (st_reg.ta_timer != 3'h0);

   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      // Timed access unlock sequence
      if (st_reg.ta_timer != 3'h0) begin
         st_next.ta_timer = st_reg.ta_timer - 3'h1;
      end else begin
         st_next.ta_step = 2'h0;
      end
      if (ta_wr && sfr_wdata == TA_KEY1) begin
         st_next.ta_step  = 2'h1;
         st_next.ta_timer = TA_WINDOW;
      end else if (ta_wr && sfr_wdata == TA_KEY2 && st_reg.ta_step == 2'h1) begin
         st_next.ta_step  = 2'h2;
         st_next.ta_timer = TA_WINDOW;
      end
      if (clk_ctrl_wr) begin
         st_next.access_stretch_field = sfr_wdata[STRETCH_LSB+:3];
      end
      if (mmap_wr && ta_open) begin
         st_next.wait_enable_bit = sfr_wdata[WAIT_EN_BIT];
         st_next.ta_step         = 2'h0;
      end
      if (sfr_wr && sfr_addr == PTR_SEL_ADDR) begin
         st_next.pointer_select_bit = sfr_wdata[PTR_SEL_BIT];
      end
      st_next.phase = st_reg.phase + 2'h1;
      case (st_reg.state)
         EDASW_IDLE: begin
            st_next.phase = 2'h0;
            if (xacc_start) begin
               st_next.state    = EDASW_FETCH;
               st_next.is_write = xacc_write;
               st_next.hold     = 1'b1;
            end
         end
         EDASW_FETCH: begin
            if (st_reg.phase == PHASE_LAST) begin
               st_next.state    = EDASW_XFER;
               st_next.mc_left  = {1'b0, st_reg.access_stretch_field} + 4'h1;
               st_next.strb_cnt = strb_clks;
               st_next.wait_hit = 1'b0;
               if (xacc_use_ptr) begin
                  st_next.addr = st_reg.pointer_select_bit ?
                                 second_data_pointer : data_ptr0;
               end else begin
                  st_next.addr = {port2_hi, work_reg_lo};
               end
            end
         end
         EDASW_XFER: begin
            // Strobe runs in the last clocks of the minimum window
            if (st_reg.mc_left == 4'h1 && st_reg.phase == 2'h1 &&
                st_reg.strb_cnt == 5'h02) begin
               st_next.rd_n = st_reg.is_write;
               st_next.wr_n = ~st_reg.is_write;
            end else if (st_reg.strb_cnt != 5'h02 &&
                         {st_reg.mc_left, 2'h0} - 6'(st_reg.phase)
                         == 6'(st_reg.strb_cnt) + 6'h01) begin
               st_next.rd_n = st_reg.is_write;
               st_next.wr_n = ~st_reg.is_write;
            end
            if (st_reg.phase == PHASE_SECOND) begin
               st_next.wait_hit = st_reg.wait_enable_bit &&
                                  !port4_bit0_pin_n;
            end
            if (st_reg.phase == PHASE_LAST) begin
               if (st_reg.mc_left > 4'h1) begin
                  st_next.mc_left = st_reg.mc_left - 4'h1;
               end else if (!st_reg.wait_hit) begin
                  st_next.state = EDASW_IDLE;
                  st_next.rd_n  = 1'b1;
                  st_next.wr_n  = 1'b1;
                  st_next.hold  = 1'b0;
                  st_next.done  = 1'b1;
               end
               // Otherwise one more machine cycle is inserted
            end
         end
         default: begin
            st_next.state = EDASW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg                      <= '0;
         st_reg.state                <= EDASW_IDLE;
         st_reg.access_stretch_field <= STRETCH_RESET;
         st_reg.rd_n                 <= 1'b1;
         st_reg.wr_n                 <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign clk_ctrl_rdata = {5'h00, st_reg.access_stretch_field};
   assign mmap_rdata    = {st_reg.wait_enable_bit, 7'h00};
   assign ptr_sel_rdata = {7'h00, st_reg.pointer_select_bit};
   assign core_hold     = st_reg.hold;
   assign xacc_done     = st_reg.done;
   assign ext_addr      = st_reg.addr;
   assign ext_rd_n      = st_reg.rd_n;
   assign ext_wr_n      = st_reg.wr_n;

   // Strobe length with no wait equals the stretch table
   logic [5:0] strb_len;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strb_len <= 6'h00;
      end else if (!(st_reg.rd_n && st_reg.wr_n)) begin
         strb_len <= strb_len + 6'h01;
      end else begin
         strb_len <= 6'h00;
      end
   end

   strobe_width_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      ($rose(st_reg.rd_n & st_reg.wr_n) && !st_reg.wait_enable_bit)
      |-> strb_len == 6'(strb_clks))
      else $error("strobe width wrong");
   fetch_len_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_reg.state == EDASW_IDLE && xacc_start)
      |=> st_reg.state == EDASW_FETCH [*4] ##1 st_reg.state == EDASW_XFER)
      else $error("fetch not four clocks");
   addr_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_reg.state == EDASW_XFER && $past(st_reg.state) == EDASW_XFER)
      |-> $stable(st_reg.addr))
      else $error("address moved");
   wait_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !st_reg.wait_enable_bit |-> !st_reg.wait_hit)
      else $error("wait seen while disabled");
   ws_protect_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !ta_open |=> $stable(st_reg.wait_enable_bit))
      else $error("wait enable changed unprotected");
   wait_extend_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      (st_reg.state == EDASW_XFER && st_reg.phase == PHASE_LAST &&
       st_reg.wait_hit) |=> st_reg.state == EDASW_XFER)
      else $error("wait cycle not inserted");
   hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      st_reg.state != EDASW_IDLE |-> st_reg.hold)
      else $error("core not held");
   done_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
      st_reg.done |-> st_reg.rd_n && st_reg.wr_n && !st_reg.hold)
      else $error("done with strobe active");
   cov_read: cover property (@(posedge sys_clk) disable iff (!arst_n)
      $fell(st_reg.rd_n));
   cov_write: cover property (@(posedge sys_clk) disable iff (!arst_n)
      $fell(st_reg.wr_n));
   cov_wait: cover property (@(posedge sys_clk) disable iff (!arst_n)
      st_reg.wait_hit && st_reg.phase == PHASE_LAST);
endmodule : edasw_core
`default_nettype wire

/* File: edasw_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module edasw_mem_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // Strobes from the device
   input  wire logic       ext_rd_n,
   input  wire logic       ext_wr_n,
   // Machine cycles to stall each access
   input  wire logic [3:0] wait_mcs,
   // Wait line, idles high
   output var  logic       port4_bit0_pin_n
);
   logic       strobe;
   logic [6:0] cnt_reg;
   assign strobe = !(ext_rd_n && ext_wr_n);
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n)
         cnt_reg <= 7'h00;
      else
         cnt_reg <= strobe ? cnt_reg + 7'h01 : 7'h00;
   end
   // Low until ready, then released high
   assign port4_bit0_pin_n = !(strobe && cnt_reg < {1'b0, wait_mcs, 2'h0});
endmodule : edasw_mem_model
`default_nettype wire

/* File: edasw_pkg.sv */
package edasw_pkg;
   localparam int          CLKS_PER_MC       = 4;
   localparam logic [2:0]  STRETCH_RESET     = 3'h1;
   localparam int          STRETCH_LSB       = 0;
   localparam int          WAIT_EN_BIT       = 7;
   localparam int          PTR_SEL_BIT       = 0;
   localparam logic [7:0]  PTR_SEL_ADDR      = 8'h86;
   localparam logic [1:0]  PHASE_SECOND      = 2'h1;
   localparam logic [1:0]  PHASE_LAST        = 2'h3;
   localparam logic [7:0]  TA_KEY1           = 8'hAA;
   localparam logic [7:0]  TA_KEY2           = 8'h55;
   localparam logic [2:0]  TA_WINDOW         = 3'h3;
   localparam logic [7:0]  CLK_CTRL_RESET    = 8'h01;
   localparam logic [7:0]  MMAP_RESET        = 8'h00;
   typedef enum logic [1:0] {
      EDASW_IDLE  = 2'b00,
      EDASW_FETCH = 2'b01,
      EDASW_XFER  = 2'b11
   } edasw_state_e;
endpackage : edasw_pkg

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import edasw_pkg::*;
   logic sys_clk, arst_n, sfr_wr, clk_ctrl_wr, mmap_wr, ta_wr;
   logic xacc_start, xacc_write, xacc_use_ptr, xacc_done, core_hold;
   logic wait_n, ext_rd_n, ext_wr_n;
   logic [7:0] sfr_addr, sfr_wdata, clk_ctrl_rdata, mmap_rdata, ptr_sel_rdata;
   logic [7:0] work_reg_lo, port2_hi;
   logic [15:0] data_ptr0, second_data_pointer, ext_addr;
   logic [3:0] wait_mcs;
   int fail_count = 0;
   int samples_checked = 0;
   edasw_core uut (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_wr(sfr_wr),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .clk_ctrl_wr(clk_ctrl_wr),
      .mmap_wr(mmap_wr), .ta_wr(ta_wr), .clk_ctrl_rdata(clk_ctrl_rdata),
      .mmap_rdata(mmap_rdata), .ptr_sel_rdata(ptr_sel_rdata),
      .xacc_start(xacc_start), .xacc_write(xacc_write),
      .xacc_use_ptr(xacc_use_ptr), .work_reg_lo(work_reg_lo),
      .port2_hi(port2_hi), .data_ptr0(data_ptr0),
      .second_data_pointer(second_data_pointer), .core_hold(core_hold),
      .xacc_done(xacc_done), .port4_bit0_pin_n(wait_n),
      .ext_addr(ext_addr), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));
   edasw_mem_model mem (.sys_clk(sys_clk), .arst_n(arst_n),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .wait_mcs(wait_mcs),
      .port4_bit0_pin_n(wait_n));
   always #10 sys_clk = ~sys_clk;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize
   // Kind 0 pointer select, 1 clock ctrl, 2 memory map, 3 key
   task automatic pulse(input int kind, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_wdata <= d;
      case (kind)
         0: sfr_wr <= 1'b1;
         1: clk_ctrl_wr <= 1'b1;
         2: mmap_wr <= 1'b1;
         default: ta_wr <= 1'b1;
      endcase
      @(posedge sys_clk);
      {sfr_wr, clk_ctrl_wr, mmap_wr, ta_wr} <= 4'h0;
      // Let the register update settle before it is read back
      @(negedge sys_clk);
   endtask : pulse
   // mw: stall asked of the memory, w: stall cycles expected
   task automatic access(input logic wr, input logic ptr, input int s,
                         input int mw, input int w, input logic [15:0] a);
      int n;
      int strb;
      int bad;
      n = 0;
      strb = 0;
      bad = 0;
      @(posedge sys_clk);
      xacc_write <= wr;
      xacc_use_ptr <= ptr;
      wait_mcs <= 4'(mw);
      xacc_start <= 1'b1;
      @(posedge sys_clk);
      xacc_start <= 1'b0;
      while (xacc_done !== 1'b1 && n < 200) begin
         @(negedge sys_clk);
         n++;
         if ((wr ? ext_wr_n : ext_rd_n) === 1'b0) begin
            strb++;
            if (ext_addr !== a) bad++;
         end
         if ((wr ? ext_rd_n : ext_wr_n) !== 1'b1) bad++;
         if (xacc_done !== 1'b1 && core_hold !== 1'b1) bad++;
      end
      check(16'(n), 16'(5 + 4 * (s + 1 + w)));
      check(16'(strb), 16'(((s == 0) ? 2 : 4 * s) + 4 * w));
      check(16'(bad), 16'h0000);
   endtask : access
   task automatic t_reset;
      check(16'(clk_ctrl_rdata), 16'h0001);
      check(16'(mmap_rdata), 16'h0000);
      check(16'(ptr_sel_rdata), 16'h0000);
      access(1'b0, 1'b0, 1, 0, 0, {port2_hi, work_reg_lo});
   endtask : t_reset
   task automatic t_stretch;
      for (int s = 0; s < 8; s++) begin
         pulse(1, 8'(s));
         check(16'(clk_ctrl_rdata), 16'(s));
         access(s[0], 1'b1, s, 0, 0, data_ptr0);
      end
   endtask : t_stretch
   task automatic t_ptr_sel;
      pulse(0, 8'hFF);
      check(16'(ptr_sel_rdata), 16'h0001);
      access(1'b1, 1'b1, 7, 0, 0, second_data_pointer);
      pulse(0, 8'h00);
      access(1'b0, 1'b1, 7, 0, 0, data_ptr0);
   endtask : t_ptr_sel
   task automatic t_wait;
      pulse(1, 8'h01);
      access(1'b0, 1'b0, 1, 3, 0, {port2_hi, work_reg_lo});
      pulse(2, 8'h80);
      check(16'(mmap_rdata), 16'h0000);
      pulse(3, TA_KEY1);
      pulse(3, TA_KEY2);
      pulse(2, 8'h80);
      check(16'(mmap_rdata), 16'h0080);
      access(1'b0, 1'b0, 1, 2, 2, {port2_hi, work_reg_lo});
      access(1'b1, 1'b1, 1, 0, 0, data_ptr0);
      access(1'b1, 1'b0, 1, 9, 9, {port2_hi, work_reg_lo});
   endtask : t_wait
   initial begin
      {sys_clk, arst_n, sfr_wr, clk_ctrl_wr, mmap_wr, ta_wr} = 6'h00;
      {xacc_start, xacc_write, xacc_use_ptr} = 3'h0;
      sfr_addr = PTR_SEL_ADDR;
      sfr_wdata = 8'h00;
      work_reg_lo = 8'h3C;
      port2_hi = 8'hA5;
      data_ptr0 = 16'h1234;
      second_data_pointer = 16'hBEEF;
      wait_mcs = 4'h0;
      repeat (10) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_stretch();
      t_ptr_sel();
      t_wait();
      summarize();
   end
   initial begin
      #100us;
      fail_count++;
      summarize();
   end
endmodule : testbench
`default_nettype wire
